/* core/psc_map.vh */
`ifndef PSC_MAP_VH
`define PSC_MAP_VH

`define PSC_DEG_LAST     9'd359
`define PSC_EAC_LO       9'd225
`define PSC_EAC_HI       9'd290
`define PSC_LAC_LO       9'd315
`define PSC_LAC_HI       9'd350
`define PSC_X12_LO       9'd20
`define PSC_X12_HI       9'd40
`define PSC_ZCM_LO       9'd295
`define PSC_ZCM_HI       9'd310
`define PSC_XFER_DEG     9'd312
`define PSC_CLUTCH_DEG   9'd300
`define PSC_CAM_LO       9'd225
`define PSC_CAM_HI       9'd358

`define PSC_CYCLE_MS     600
`define PSC_CLK_KHZ      25000
`define PSC_DEG_CLKS     ((`PSC_CYCLE_MS * `PSC_CLK_KHZ) / 360)

`define PSC_OFF_CTRL     8'h00
`define PSC_OFF_STATUS   8'h04
`define PSC_OFF_NPCNT    8'h08
`define PSC_OFF_ZSCNT    8'h0C

`define PSC_CTRL_RUN     0
`define PSC_CTRL_CLR     1
`define PSC_CTRL_RESET   1'b0

`define PSC_ST_EAC       0
`define PSC_ST_LAC       1
`define PSC_ST_ZSL       2
`define PSC_ST_NPL       3
`define PSC_ST_ZCM       4
`define PSC_ST_CLUTCH    5
`define PSC_ST_SPEED     6
`define PSC_ST_DEG_LO    16

`endif

/* core/psc_latch.v */
`timescale 1ns/10ps
`include "psc_map.vh"

module psc_latch (
  input  wire i_clk,   // system clock
  input  wire i_rst,   // sync reset, high
  input  wire i_pick,  // pick impulse
  input  wire i_hold,  // hold cam contact closed
  output reg  o_q      // latch state
);

  // pick wins over a cam opening in the same cycle
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_q <= 1'b0;
    end else begin
      o_q <= i_pick | (o_q & i_hold);
    end
  end

endmodule

/* core/psc_core.v */
`timescale 1ns/10ps
`include "psc_map.vh"

module psc_core #(
  parameter NBARS      = 43,
  parameter P_DEG_CLKS = `PSC_DEG_CLKS
) (
  input  wire             i_clk,             // system clock
  input  wire             i_rst,             // sync reset, high
  input  wire             i_psel,            // apb select
  input  wire             i_penable,         // apb enable
  input  wire             i_pwrite,          // apb write
  input  wire [7:0]       i_paddr,           // apb byte address
  input  wire [31:0]      i_pwdata,          // apb write data
  output reg  [31:0]      o_prdata,          // apb read data
  output wire             o_pready,          // apb ready
  output wire             o_pslverr,         // apb error
  input  wire             i_card_cycle,      // this cycle feeds cards
  input  wire             i_program_cycle,   // this cycle is a program cycle
  input  wire             i_list_hub,        // list hub impulse
  input  wire             i_zone_sup_hub,    // common suppress hub impulse
  input  wire             i_zone_sup_brush,  // x or 12 brush impulse
  input  wire             i_nonprint_hub,    // non-print via pilot selector
  input  wire [NBARS-1:0] i_zone_read,       // zoning from second brushes
  output reg              o_early_cycle_window, // early window active
  output reg              o_late_cycle_window,  // late window active
  output reg              o_all_cycles_imp,  // all cycles hub emit
  output reg              o_card_cycles_imp, // card cycles hub emit
  output reg              o_program_imp,     // program level hub emit
  output reg              o_zone_control_magnet, // zone control magnet
  output reg              o_zone_transfer_relay, // zone transfer relay
  output reg  [NBARS-1:0] o_bar_zone,        // zoning on type bars
  output reg              o_print_clutch,    // print clutch magnet
  output reg              o_speed_shift_relay, // high speed feed
  output reg              o_carriage_space,  // carriage space pulse
  output wire             o_zone_suppress_latch, // zone latch state
  output wire             o_nonprint_latch   // non-print latch state
);

  localparam ST_IDLE = 3'b001;
  localparam ST_RUN  = 3'b010;
  localparam ST_WRAP = 3'b100;

  reg  [2:0]  state;
  reg  [2:0]  next_state;
  reg  [15:0] tick_cnt;
  reg  [8:0]  deg;
  reg         ctrl_run;
  reg         list_req;
  reg         zcm_done;
  reg         clutch_done;
  reg         np_seen;
  reg         zs_seen;
  reg  [15:0] np_cnt;
  reg  [15:0] zs_cnt;
  wire        deg_tick;
  wire        cycle_end;
  wire        in_eac;
  wire        in_lac;
  wire        in_any;
  wire        in_x12;
  wire        in_zcm;
  wire        cam_closed;
  wire        zs_pick;
  wire        np_pick;
  wire        zcm_ok;
  wire        apb_wr;
  wire        apb_setup;
  reg  [31:0] rd_word;

  function in_span;
    input [8:0] d;
    input [8:0] lo;
    input [8:0] hi;
    begin
      in_span = (d >= lo) && (d <= hi);
    end
  endfunction

  function addr_hit;
    input [7:0] a;
    begin
      addr_hit = (a == `PSC_OFF_CTRL) || (a == `PSC_OFF_STATUS) ||
                 (a == `PSC_OFF_NPCNT) || (a == `PSC_OFF_ZSCNT);
    end
  endfunction

  // machine cycle sequencing
  always @* begin
    case (state)
      ST_IDLE: begin
        next_state = ctrl_run ? ST_RUN : ST_IDLE;
      end
      ST_RUN: begin
        next_state = cycle_end ? ST_WRAP : ST_RUN;
      end
      ST_WRAP: begin
        next_state = ctrl_run ? ST_RUN : ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge i_clk) begin
    if (i_rst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign deg_tick  = (state == ST_RUN) && (tick_cnt == P_DEG_CLKS[15:0] - 16'h0001);
  assign cycle_end = deg_tick && (deg == `PSC_DEG_LAST);

  // a stop request lets the running cycle finish first: it parks at 0 degrees between cycles
  always @(posedge i_clk) begin
    if (i_rst) begin
      tick_cnt <= 16'h0000;
      deg      <= 9'h000;
    end else if (state != ST_RUN) begin
      tick_cnt <= 16'h0000;
      deg      <= 9'h000;
    end else if (deg_tick) begin
      tick_cnt <= 16'h0000;
      deg      <= cycle_end ? 9'h000 : deg + 9'h001;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
    end
  end

  assign in_eac     = (state == ST_RUN) && in_span(deg, `PSC_EAC_LO, `PSC_EAC_HI);
  assign in_lac     = (state == ST_RUN) && in_span(deg, `PSC_LAC_LO, `PSC_LAC_HI);
  assign in_any     = in_eac | in_lac;
  assign in_x12     = (state == ST_RUN) && in_span(deg, `PSC_X12_LO, `PSC_X12_HI);
  assign in_zcm     = (state == ST_RUN) && in_span(deg, `PSC_ZCM_LO, `PSC_ZCM_HI);
  assign cam_closed = (state == ST_RUN) && in_span(deg, `PSC_CAM_LO, `PSC_CAM_HI);

  // hub impulses outside the windows, and brush impulses outside deg 20..40, are simply not seen
  assign zs_pick = (i_zone_sup_hub & in_any) | (i_zone_sup_brush & in_x12);
  assign np_pick = i_nonprint_hub & in_any;

  psc_latch u_zone_latch (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_pick (zs_pick),
    .i_hold (cam_closed),
    .o_q    (o_zone_suppress_latch)
  );

  psc_latch u_np_latch (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_pick (np_pick),
    .i_hold (cam_closed),
    .o_q    (o_nonprint_latch)
  );

  // brush x/12 comes early, before the hold cam closes: keep it until the cycle ends
  always @(posedge i_clk) begin
    if (i_rst) begin
      zs_seen <= 1'b0;
    end else if (cycle_end) begin
      zs_seen <= 1'b0;
    end else if (zs_pick) begin
      zs_seen <= 1'b1;
    end
  end

  // the list hub is gated to the early window only
  always @(posedge i_clk) begin
    if (i_rst) begin
      list_req <= 1'b0;
    end else if (i_list_hub & in_eac) begin
      list_req <= 1'b1;
    end else if (cycle_end) begin
      list_req <= 1'b0;
    end
  end

  assign zcm_ok = i_card_cycle & ~zs_seen & ~o_zone_suppress_latch & ~o_nonprint_latch;

  always @(posedge i_clk) begin
    if (i_rst) begin
      o_zone_control_magnet <= 1'b0;
      o_zone_transfer_relay <= 1'b0;
      zcm_done              <= 1'b0;
    end else begin
      o_zone_control_magnet <= in_zcm & zcm_ok;
      o_zone_transfer_relay <= in_zcm & zcm_ok;
      if (cycle_end) begin
        zcm_done <= 1'b0;
      end else if (o_zone_control_magnet) begin
        zcm_done <= 1'b1;
      end
    end
  end

  // each bar takes its zoning only once the magnet has worked this cycle;
  // the transfer relay has already dropped by then, so the magnet memory gates the load
  genvar b;
  generate
    for (b = 0; b < NBARS; b = b + 1) begin : g_bar
      always @(posedge i_clk) begin
        if (i_rst) begin
          o_bar_zone[b] <= 1'b0;
        end else if (cycle_end) begin
          o_bar_zone[b] <= 1'b0;
        end else if ((deg == `PSC_XFER_DEG) && deg_tick && zcm_done) begin
          o_bar_zone[b] <= i_zone_read[b];
        end
      end
    end
  endgenerate

  // clutch picks after the early window, so a non-print there is already latched
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_print_clutch <= 1'b0;
      clutch_done    <= 1'b0;
    end else if (cycle_end) begin
      o_print_clutch <= 1'b0;
      clutch_done    <= 1'b0;
    end else begin
      o_print_clutch <= (deg == `PSC_CLUTCH_DEG) && (state == ST_RUN) &&
                        (list_req | i_program_cycle) && ~o_nonprint_latch;
      if (o_print_clutch) begin
        clutch_done <= 1'b1;
      end
    end
  end

  // spacing only follows a cycle in which the print cams turned
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_carriage_space <= 1'b0;
    end else begin
      o_carriage_space <= cycle_end & clutch_done & ~np_seen;
    end
  end

  always @(posedge i_clk) begin
    if (i_rst) begin
      np_seen             <= 1'b0;
      o_speed_shift_relay <= 1'b0;
    end else begin
      o_speed_shift_relay <= o_nonprint_latch;
      if (cycle_end) begin
        np_seen <= 1'b0;
      end else if (o_nonprint_latch) begin
        np_seen <= 1'b1;
      end
    end
  end

  // hub emitters run in both windows
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_early_cycle_window <= 1'b0;
      o_late_cycle_window  <= 1'b0;
      o_all_cycles_imp     <= 1'b0;
      o_card_cycles_imp    <= 1'b0;
      o_program_imp        <= 1'b0;
    end else begin
      o_early_cycle_window <= in_eac;
      o_late_cycle_window  <= in_lac;
      o_all_cycles_imp     <= in_any;
      o_card_cycles_imp    <= in_any & i_card_cycle;
      o_program_imp        <= in_any & i_program_cycle;
    end
  end

  // apb slave: zero wait states, unmapped addresses error
  assign apb_setup = i_psel & ~i_penable;
  assign apb_wr    = i_psel & i_penable & i_pwrite & addr_hit(i_paddr);
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~addr_hit(i_paddr);

  always @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_run <= `PSC_CTRL_RESET;
    end else if (apb_wr && (i_paddr == `PSC_OFF_CTRL)) begin
      ctrl_run <= i_pwdata[`PSC_CTRL_RUN];
    end
  end

  // counters saturate rather than wrap so a long run never looks quiet
  always @(posedge i_clk) begin
    if (i_rst) begin
      np_cnt <= 16'h0000;
      zs_cnt <= 16'h0000;
    end else if (apb_wr && (i_paddr == `PSC_OFF_CTRL) && i_pwdata[`PSC_CTRL_CLR]) begin
      np_cnt <= 16'h0000;
      zs_cnt <= 16'h0000;
    end else if (cycle_end) begin
      if (np_seen && (np_cnt != 16'hFFFF)) begin
        np_cnt <= np_cnt + 16'h0001;
      end
      if (zs_seen && (zs_cnt != 16'hFFFF)) begin
        zs_cnt <= zs_cnt + 16'h0001;
      end
    end
  end

  always @* begin
    rd_word = 32'h00000000;
    case (i_paddr)
      `PSC_OFF_CTRL: begin
        rd_word[`PSC_CTRL_RUN] = ctrl_run;
      end
      `PSC_OFF_STATUS: begin
        rd_word[`PSC_ST_EAC]    = o_early_cycle_window;
        rd_word[`PSC_ST_LAC]    = o_late_cycle_window;
        rd_word[`PSC_ST_ZSL]    = o_zone_suppress_latch;
        rd_word[`PSC_ST_NPL]    = o_nonprint_latch;
        rd_word[`PSC_ST_ZCM]    = o_zone_control_magnet;
        rd_word[`PSC_ST_CLUTCH] = o_print_clutch;
        rd_word[`PSC_ST_SPEED]  = o_speed_shift_relay;
        rd_word[`PSC_ST_DEG_LO +: 9] = deg;
      end
      `PSC_OFF_NPCNT: begin
        rd_word[15:0] = np_cnt;
      end
      `PSC_OFF_ZSCNT: begin
        rd_word[15:0] = zs_cnt;
      end
      default: begin
        rd_word = 32'h00000000;
      end
    endcase
  end

  // read data is captured in the setup cycle and stands through the access cycle
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_prdata <= 32'h00000000;
    end else if (apb_setup) begin
      o_prdata <= rd_word;
    end
  end

endmodule

/* sim/psc_assertions.sv */
`timescale 1ns/10ps
module psc_assertions #(
  parameter NBARS      = 43,
  parameter P_DEG_CLKS = 4
) (
  input wire logic             i_clk,
  input wire logic             i_rst,
  input wire logic             o_early_cycle_window,
  input wire logic             o_late_cycle_window,
  input wire logic             o_all_cycles_imp,
  input wire logic             o_card_cycles_imp,
  input wire logic             o_program_imp,
  input wire logic             o_zone_control_magnet,
  input wire logic             o_zone_transfer_relay,
  input wire logic [NBARS-1:0] o_bar_zone,
  input wire logic             o_print_clutch,
  input wire logic             o_speed_shift_relay,
  input wire logic             o_zone_suppress_latch,
  input wire logic             o_nonprint_latch
);
  logic mag_seen;
  int   held;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // magnet memory cleared at early window start, long before bars load
  always_ff @(posedge i_clk) begin
    if (i_rst || $rose(o_early_cycle_window)) mag_seen <= 1'b0;
    else if (o_zone_control_magnet) mag_seen <= 1'b1;
    if (i_rst || !(o_zone_suppress_latch || o_nonprint_latch)) held <= 0;
    else held <= held + 1;
  end
  property p_win_excl; !(o_early_cycle_window && o_late_cycle_window); endproperty
  a_win_excl: assert property (p_win_excl) else $error("windows overlap");
  property p_all_emit; o_all_cycles_imp == (o_early_cycle_window || o_late_cycle_window); endproperty
  a_all_emit: assert property (p_all_emit) else $error("all cycles emit off window");
  property p_sub_emit; (o_card_cycles_imp || o_program_imp) |-> o_all_cycles_imp; endproperty
  a_sub_emit: assert property (p_sub_emit) else $error("card or program emit off window");
  property p_zsl_mag; o_zone_suppress_latch |-> !o_zone_control_magnet; endproperty
  a_zsl_mag: assert property (p_zsl_mag) else $error("magnet under zone latch");
  property p_np_block;
    o_nonprint_latch |-> !(o_print_clutch || o_zone_control_magnet || o_zone_transfer_relay);
  endproperty
  a_np_block: assert property (p_np_block) else $error("print path under non-print");
  property p_speed_on; $rose(o_nonprint_latch) |=> o_speed_shift_relay; endproperty
  a_speed_on: assert property (p_speed_on) else $error("speed relay late");
  property p_speed_off; $fell(o_nonprint_latch) |=> !o_speed_shift_relay; endproperty
  a_speed_off: assert property (p_speed_off) else $error("speed relay stuck");
  property p_release; held < 360 * P_DEG_CLKS; endproperty
  a_release: assert property (p_release) else $error("latch held past a cycle");
  property p_bar_mag; (o_bar_zone != '0) && ($past(o_bar_zone) == '0) |-> mag_seen; endproperty
  a_bar_mag: assert property (p_bar_mag) else $error("bars zoned without magnet");
endmodule

bind psc_core psc_assertions #(.NBARS(NBARS), .P_DEG_CLKS(P_DEG_CLKS)) chk_u (
  .i_clk, .i_rst, .o_early_cycle_window, .o_late_cycle_window, .o_all_cycles_imp,
  .o_card_cycles_imp, .o_program_imp, .o_zone_control_magnet, .o_zone_transfer_relay,
  .o_bar_zone, .o_print_clutch, .o_speed_shift_relay, .o_zone_suppress_latch,
  .o_nonprint_latch);

/* sim/psc_panel_model.sv */
`timescale 1ns/10ps
module psc_panel_model #(
  parameter DEG = 4
) (
  input  wire logic        i_clk,     // system clock
  input  wire logic [4:0]  i_want,    // list early, list late, np, zone hub, brush
  input  wire logic        i_early,   // early window
  input  wire logic        i_late,    // late window
  input  wire logic        i_all,     // all cycles emit
  input  wire logic        i_card,    // card cycles emit
  output wire logic        o_list,    // list hub
  output wire logic        o_zhub,    // common suppress hub
  output wire logic        o_brush,   // x or 12 brush
  output wire logic        o_np,      // non-print hub
  output wire logic [42:0] o_zread    // second brush zoning
);
  localparam logic [42:0] PAT = 43'h5A5_C3C3_A5A5;
  logic late_d = 1'b0;
  int   cnt    = 100000;
  // brush timing counts from late window end, so counts 30..45 fall well inside deg 20..40
  always @(posedge i_clk) begin
    late_d <= i_late;
    if (late_d && !i_late) cnt <= 0;
    else if (cnt < 100000) cnt <= cnt + 1;
  end
  assign o_list  = i_all && (i_want[0] ? i_early : i_want[1] && i_late);
  assign o_zhub  = i_want[3] && i_all;
  assign o_brush = i_want[4] && cnt >= 30 * DEG && cnt < 45 * DEG;
  assign o_np    = i_want[2] && i_card;
  // brushes not over a row: show the inverse, not a stale copy
  assign o_zread = (i_early || i_late) ? ~PAT : PAT;
endmodule

/* sim/tb_top.sv */
`timescale 1ns/10ps
`include "psc_map.vh"
module tb_top;
  localparam D = 4;
  localparam logic [42:0] PAT = 43'h5A5_C3C3_A5A5;
  logic        i_clk = 1'b0, i_rst = 1'b1, i_psel = 1'b0, i_penable = 1'b0;
  logic        i_pwrite = 1'b0, i_card_cycle = 1'b0, i_program_cycle = 1'b0;
  logic [7:0]  i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0, o_prdata, r;
  logic [42:0] i_zone_read, o_bar_zone, bars;
  logic        o_pready, o_pslverr, i_list_hub, i_zone_sup_hub, i_zone_sup_brush;
  logic        i_nonprint_hub, o_early_cycle_window, o_late_cycle_window, o_all_cycles_imp;
  logic        o_card_cycles_imp, o_program_imp, o_zone_control_magnet, o_zone_transfer_relay;
  logic        o_print_clutch, o_speed_shift_relay, o_carriage_space, o_zone_suppress_latch;
  logic        o_nonprint_latch, e, clr = 1'b0, lastpr = 1'b0, mask = 1'b0;
  logic [4:0]  want = 5'h00;
  logic [5:0]  seen;
  int          fails = 0, check_count = 0, ticks = 0;

  psc_core #(.NBARS(43), .P_DEG_CLKS(D)) dut_u (.i_clk, .i_rst, .i_psel, .i_penable,
    .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_card_cycle,
    .i_program_cycle, .i_list_hub, .i_zone_sup_hub, .i_zone_sup_brush, .i_nonprint_hub,
    .i_zone_read, .o_early_cycle_window, .o_late_cycle_window, .o_all_cycles_imp,
    .o_card_cycles_imp, .o_program_imp, .o_zone_control_magnet, .o_zone_transfer_relay,
    .o_bar_zone, .o_print_clutch, .o_speed_shift_relay, .o_carriage_space,
    .o_zone_suppress_latch, .o_nonprint_latch);
  psc_panel_model #(.DEG(D)) pan_u (.i_clk, .i_want(want), .i_early(o_early_cycle_window),
    .i_late(o_late_cycle_window), .i_all(o_all_cycles_imp), .i_card(o_card_cycles_imp),
    .o_list(i_list_hub), .o_zhub(i_zone_sup_hub), .o_brush(i_zone_sup_brush),
    .o_np(i_nonprint_hub), .o_zread(i_zone_read));

  always #20 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    ticks <= ticks + 1;
    if (ticks == 40000) begin
      fails = fails + 1;
      conclude();
    end
    if (clr) begin
      seen <= 6'h00;
      bars <= 43'h0;
    end else begin
      seen <= seen | ({o_program_imp, o_card_cycles_imp, o_carriage_space, o_speed_shift_relay,
                       o_print_clutch, o_zone_control_magnet | o_zone_transfer_relay} &
                      (mask ? 6'h08 : 6'h3F));
      if (o_bar_zone != 43'h0 && !mask) bars <= o_bar_zone;
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    @(posedge i_clk);
    while (o_pready !== 1'b1) @(posedge i_clk);
    r = o_prdata;
    e = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  // one frame runs from one late window end to the next; the previous cycle's tail
  // (cam hold, loaded bars, speed relay) is masked, only its spacing pulse is kept
  task automatic frame(input logic [4:0] w, input logic card, input logic prog);
    logic pr, mg;
    pr = (prog || w[0]) && !w[2];
    mg = card && w[4:2] == 3'b000;
    want <= w;
    i_card_cycle <= card;
    i_program_cycle <= prog;
    clr <= 1'b1;
    mask <= 1'b1;
    @(posedge i_clk);
    clr <= 1'b0;
    repeat (10 * D) @(posedge i_clk);
    mask <= 1'b0;
    @(negedge o_late_cycle_window);
    @(posedge i_clk);
    chk(seen[0], mg);
    chk(seen[1], pr);
    chk(seen[2], w[2]);
    chk(seen[3], lastpr);
    chk(seen[5:4], {prog, card});
    chk(bars, mg ? PAT : 43'h0);
    lastpr = pr;
  endtask

  task automatic conclude();
    if (fails == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    apb(1'b0, `PSC_OFF_STATUS, 32'h0);
    chk(r, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk({e, r}, {1'b1, 32'h0});
    apb(1'b1, `PSC_OFF_CTRL, 32'h1);
    @(negedge o_late_cycle_window);
    @(posedge i_clk);
    frame(5'h01, 1'b1, 1'b0);
    frame(5'h05, 1'b1, 1'b0);
    frame(5'h08, 1'b1, 1'b1);
    frame(5'h11, 1'b1, 1'b0);
    frame(5'h02, 1'b0, 1'b0);
    frame(5'h00, 1'b1, 1'b0);
    frame(5'h00, 1'b0, 1'b1);
    apb(1'b1, `PSC_OFF_NPCNT, 32'h5);
    apb(1'b0, `PSC_OFF_NPCNT, 32'h0);
    chk(r, 32'h1);
    apb(1'b0, `PSC_OFF_ZSCNT, 32'h0);
    chk(r, 32'h2);
    apb(1'b1, `PSC_OFF_CTRL, 32'h3);
    apb(1'b0, `PSC_OFF_NPCNT, 32'h0);
    chk(r, 32'h0);
    apb(1'b0, `PSC_OFF_CTRL, 32'h0);
    chk(r, 32'h1);
    conclude();
  end
endmodule
